// ==== design/umc_modem_irq.sv ====
// modem control, modem status and interrupt logic with an apb register port
//
// Notes on behaviour
// - control bit 0 drives dtr low when set; loopback feeds status bit 5.
// - control bit 1 drives rts low unless auto-rts; loopback feeds status bit 4.
// - control bit 2 enables the fifo ready summary; loopback feeds status bit 6.
// - control bit 3 drives interrupt output, else high impedance; loopback bit 7.
// - control bit 4 loops control bits into status and tx into rx.
// - control bit 5 enables resume on any character.
// - control bit 6 grants access to threshold and trigger registers while enhanced write enable set.
// - control bit 7 selects divide by four prescale of the input clock.
// - control bits 7..5 writable only when enhanced write enable set.
// - status bits 0,1,3 latch cts, dsr, cd changes; cleared on read.
// - status bit 2 latches ri low-to-high only; cleared on read.
// - status bits 4..7 show inverted pins, or control bits in loopback.
// - enable bits 0..3 gate rx, tx, line and modem interrupts onto output.
// - enable bit 4 selects sleep mode.
// - enable bits 5..7 gate xoff, rts and cts change interrupts.
// - enable bits 7..4 writable only when enhanced write enable set.
// - re-enabled tx interrupt waits for fresh tx fifo data.
// - identification bit 0 is low while pending; register read only.
// - identification bits 3..1 code the highest priority source.
// - identification bit 4 set on pause or special character.
// - identification bit 5 marks cts or rts inactive transition.
// - identification bits 7,6 mirror fifo enable.
// - identification codes follow fixed priority from line error down to flow.
// - enhanced feature bit 4 protects enhanced enable and control bits.
// - auto-rts raises rts at halt level, lowers at restore level.
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module umc_modem_irq
  import umc_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cts_n,
  input  wire logic        dsr_n,
  input  wire logic        ri_n,
  input  wire logic        cd_n,
  output logic             dtr_n,
  output logic             rts_n,
  output logic             irq,
  output logic             irq_oe,
  input  wire umc_src_t    src,
  input  wire logic        tx_fifo_write,
  input  wire logic        rx_halt,
  input  wire logic        rx_restore,
  input  wire logic        tx_serial,
  output logic             rx_serial_loop,
  output logic             loopback,
  output logic             fifo_rdy_en,
  output logic             xon_any_en,
  output logic             thresh_access,
  output logic             baud_tick,
  output logic             sleep_mode
);
  logic [7:0] modem_control;
  logic [7:0] interrupt_enable;
  logic [7:0] enhanced_feature_reg;
  logic [7:0] fifo_control_reg;
  logic [3:0] delta;
  logic       auto_rts_hold;
  logic       tx_armed;
  logic       tick_raw;
  umc_modem_t pins_lvl;
  umc_modem_t modem_now;
  umc_modem_t modem_prev;
  logic [5:0] next_id;
  logic       next_pend;
  logic       ri_src_prev;

  wire logic wr = psel && penable && pwrite;
  wire logic rd = psel && penable && !pwrite;
  wire logic enh_we = enhanced_feature_reg[UMC_EFEAT_WE_BIT];
  wire logic auto_rts = enhanced_feature_reg[UMC_EFEAT_ARTS_BIT];
  wire logic lb = modem_control[4];
  // ri counts the pin going inactive, or the control bit rising in loopback
  wire logic ri_src = lb ? modem_control[2] : pins_lvl.ri;

  function automatic logic [7:0] umc_protect(input logic [7:0] old_v, input logic [7:0] new_v,
                                             input logic [7:0] mask, input logic we);
    umc_protect = we ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  function automatic logic umc_hit(input logic [11:0] addr, input logic [11:0] ofs);
    umc_hit = (addr[11:2] == ofs[11:2]);
  endfunction

  umc_sync #(
    .WIDTH (4),
    .INIT  (4'hf)
  ) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     ({cd_n, ri_n, dsr_n, cts_n}),
    .level   (pins_lvl)
  );

  umc_prescale #(
    .DIV (UMC_PRESCALE_DIV)
  ) u_pre (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .div_sel (modem_control[7]),
    .tick    (tick_raw)
  );

  // modem sources: inverted pins, or control bits in loopback
  always_comb begin
    if (lb) begin
      modem_now.cts = modem_control[1];
      modem_now.dsr = modem_control[0];
      modem_now.ri  = modem_control[2];
      modem_now.cd  = modem_control[3];
    end else begin
      modem_now = ~pins_lvl;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modem_control <= UMC_MCTL_RST;
    end else if (wr && umc_hit(paddr, UMC_OFS_MCTL)) begin
      modem_control <= umc_protect(modem_control, pwdata[7:0], UMC_ENH_MASK_MCTL, enh_we);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_enable <= UMC_IEN_RST;
    end else if (wr && umc_hit(paddr, UMC_OFS_IEN)) begin
      interrupt_enable <= umc_protect(interrupt_enable, pwdata[7:0], UMC_ENH_MASK_IEN,
                                      enh_we);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      enhanced_feature_reg <= UMC_EFEAT_RST;
      fifo_control_reg     <= UMC_FCTL_RST;
    end else begin
      if (wr && umc_hit(paddr, UMC_OFS_EFEAT)) begin
        enhanced_feature_reg <= pwdata[7:0];
      end
      if (wr && umc_hit(paddr, UMC_OFS_FCTL)) begin
        fifo_control_reg <= umc_protect(fifo_control_reg, pwdata[7:0], 8'h30, enh_we);
      end
    end
  end

  // delta flags: a change in the read cycle survives the clear
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      modem_prev  <= '0;
      delta       <= '0;
      ri_src_prev <= 1'b1; // idle pin level, so no false edge after reset
    end else begin
      modem_prev  <= modem_now;
      ri_src_prev <= ri_src;
      delta[0] <= (modem_now.cts ^ modem_prev.cts) |
                  (delta[0] & ~(rd && umc_hit(paddr, UMC_OFS_MSTAT)));
      delta[1] <= (modem_now.dsr ^ modem_prev.dsr) |
                  (delta[1] & ~(rd && umc_hit(paddr, UMC_OFS_MSTAT)));
      delta[2] <= (ri_src & ~ri_src_prev) |
                  (delta[2] & ~(rd && umc_hit(paddr, UMC_OFS_MSTAT)));
      delta[3] <= (modem_now.cd ^ modem_prev.cd) |
                  (delta[3] & ~(rd && umc_hit(paddr, UMC_OFS_MSTAT)));
    end
  end

  // tx interrupt re-arm: disabling drops it until new fifo data
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_armed <= 1'b0;
    end else if (tx_fifo_write) begin
      tx_armed <= 1'b1;
    end else if (!interrupt_enable[1]) begin
      tx_armed <= 1'b0;
    end
  end

  // auto-rts hysteresis between halt and restore levels
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      auto_rts_hold <= 1'b0;
    end else if (!auto_rts) begin
      auto_rts_hold <= 1'b0;
    end else if (rx_halt) begin
      auto_rts_hold <= 1'b1;
    end else if (rx_restore) begin
      auto_rts_hold <= 1'b0;
    end
  end

  // priority encode of enabled sources
  always_comb begin
    next_pend = 1'b1;
    if (interrupt_enable[2] && src.line_err) begin
      next_id = UMC_ID_LSR;
    end else if (interrupt_enable[0] && src.rx_timeout) begin
      next_id = UMC_ID_RTO;
    end else if (interrupt_enable[0] && src.rx_ready) begin
      next_id = UMC_ID_RHR;
    end else if (interrupt_enable[1] && src.tx_empty && tx_armed) begin
      next_id = UMC_ID_THR;
    end else if (interrupt_enable[3] && |delta) begin
      next_id = UMC_ID_MODEM;
    end else if (interrupt_enable[5] && src.xoff_char) begin
      next_id = UMC_ID_XOFF;
    end else if ((interrupt_enable[6] && src.rts_rise) ||
                 (interrupt_enable[7] && src.cts_rise)) begin
      next_id = UMC_ID_FLOW;
    end else begin
      next_id   = UMC_ID_NONE;
      next_pend = 1'b0;
    end
  end

  logic [5:0] id_code;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      id_code <= UMC_ID_NONE;
      irq     <= 1'b0;
    end else begin
      id_code <= next_id;
      irq     <= next_pend;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dtr_n          <= 1'b1;
      rts_n          <= 1'b1;
      irq_oe         <= 1'b0;
      loopback       <= 1'b0;
      fifo_rdy_en    <= 1'b0;
      xon_any_en     <= 1'b0;
      thresh_access  <= 1'b0;
      sleep_mode     <= 1'b0;
      baud_tick      <= 1'b0;
      rx_serial_loop <= 1'b1;
    end else begin
      dtr_n          <= lb | ~modem_control[0];
      rts_n          <= lb | (auto_rts ? auto_rts_hold : ~modem_control[1]);
      irq_oe         <= modem_control[3];
      loopback       <= lb;
      fifo_rdy_en    <= modem_control[2] & ~lb;
      xon_any_en     <= modem_control[5];
      thresh_access  <= modem_control[6] & enh_we;
      sleep_mode     <= interrupt_enable[4];
      baud_tick      <= tick_raw;
      rx_serial_loop <= lb ? tx_serial : 1'b1;
    end
  end

  // apb: zero-wait answer; unmapped reads zero with slave error
  logic [7:0] rd_byte;
  logic       rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    if (umc_hit(paddr, UMC_OFS_MCTL)) begin
      rd_byte = modem_control;
    end else if (umc_hit(paddr, UMC_OFS_MSTAT)) begin
      rd_byte = {modem_now.cd, modem_now.ri, modem_now.dsr, modem_now.cts, delta};
    end else if (umc_hit(paddr, UMC_OFS_IEN)) begin
      rd_byte = interrupt_enable;
    end else if (umc_hit(paddr, UMC_OFS_IID)) begin
      rd_byte = {{2{fifo_control_reg[0]}}, id_code};
    end else if (umc_hit(paddr, UMC_OFS_EFEAT)) begin
      rd_byte = enhanced_feature_reg;
    end else if (umc_hit(paddr, UMC_OFS_FCTL)) begin
      rd_byte = fifo_control_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (!rd_ok || (pwrite && umc_hit(paddr, UMC_OFS_IID)));
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : prdata;
    end
  end

  AST_IRQ_BIT0: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irq |-> id_code[0] == 1'b0) else $error("pending irq with id bit0 high");
  AST_IRQ_NONE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !irq |-> id_code == UMC_ID_NONE) else $error("idle irq with code");
  AST_LSR_FIRST: assert property (@(posedge sys_clk) disable iff (!reset_n)
    interrupt_enable[2] && src.line_err |=> id_code == UMC_ID_LSR)
    else $error("line error not highest");
  AST_DTR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !lb && modem_control[0] |=> !dtr_n) else $error("dtr not active");
  AST_OE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(modem_control[3]) |=> irq_oe) else $error("irq enable late");
  AST_MCTL_PROT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enh_we |=> modem_control[7:5] == $past(modem_control[7:5]))
    else $error("protected control bits changed");
  AST_IEN_PROT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enh_we |=> interrupt_enable[7:4] == $past(interrupt_enable[7:4]))
    else $error("protected enable bits changed");
  AST_RI_EDGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ri_src && !ri_src_prev |=> delta[2]) else $error("ri edge lost");
  AST_TX_REARM: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(interrupt_enable[1]) && !tx_fifo_write && !$past(tx_fifo_write)
    |=> id_code != UMC_ID_THR) else $error("tx irq without new data");
  AST_MIRROR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rd && umc_hit(paddr, UMC_OFS_IID) |=> prdata[7:6] == {2{$past(fifo_control_reg[0])}})
    else $error("fifo enable mirror wrong");

  // checks on the control outputs, the status clear, the modem interrupt and the slave error
  AST_LOOP_LINES: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lb |=> rts_n && dtr_n) else $error("modem lines driven in loopback");
  AST_FRDY_LB: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lb |=> !fifo_rdy_en) else $error("fifo ready enabled in loopback");
  AST_OE_LOW: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !modem_control[3] |=> !irq_oe) else $error("irq driven while disabled");
  AST_XON: assert property (@(posedge sys_clk) disable iff (!reset_n)
    modem_control[5] |=> xon_any_en) else $error("resume on any off");
  AST_THACC: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enh_we |=> !thresh_access) else $error("threshold access without enable");
  AST_SLEEP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    interrupt_enable[4] |=> sleep_mode) else $error("sleep not entered");
  AST_DELTA_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    rd && umc_hit(paddr, UMC_OFS_MSTAT) && modem_now == modem_prev && !(ri_src && !ri_src_prev)
    |=> delta == 4'h0) else $error("status read left delta set");
  AST_IRQ_MODEM: assert property (@(posedge sys_clk) disable iff (!reset_n)
    interrupt_enable[3] && |delta |=> irq) else $error("modem irq missing");
  AST_PSLV: assert property (@(posedge sys_clk) disable iff (!reset_n)
    pslverr |-> pready) else $error("slave error without ready");
endmodule
`default_nettype wire

// ==== design/umc_pkg.sv ====
// shared constants and types for the modem control and interrupt block
package umc_pkg;

  localparam logic [11:0] UMC_OFS_MCTL   = 12'h000;
  localparam logic [11:0] UMC_OFS_MSTAT  = 12'h004;
  localparam logic [11:0] UMC_OFS_IEN    = 12'h008;
  localparam logic [11:0] UMC_OFS_IID    = 12'h00c;
  localparam logic [11:0] UMC_OFS_EFEAT  = 12'h010;
  localparam logic [11:0] UMC_OFS_FCTL   = 12'h014;
  localparam logic [11:0] UMC_OFS_EVENT  = 12'h018;
  localparam logic [11:0] UMC_OFS_LEVEL  = 12'h01c;

  localparam logic [7:0]  UMC_MCTL_RST   = 8'h00;
  localparam logic [7:0]  UMC_IEN_RST    = 8'h00;
  localparam logic [7:0]  UMC_EFEAT_RST  = 8'h00;
  localparam logic [7:0]  UMC_FCTL_RST   = 8'h00;
  localparam logic [7:0]  UMC_ENH_MASK_MCTL = 8'he0;
  localparam logic [7:0]  UMC_ENH_MASK_IEN  = 8'hf0;
  localparam int          UMC_EFEAT_WE_BIT  = 4;
  localparam int          UMC_EFEAT_ARTS_BIT = 6;
  localparam int          UMC_PRESCALE_DIV  = 4;

  localparam logic [5:0]  UMC_ID_NONE  = 6'h01;
  localparam logic [5:0]  UMC_ID_LSR   = 6'h06;
  localparam logic [5:0]  UMC_ID_RTO   = 6'h0c;
  localparam logic [5:0]  UMC_ID_RHR   = 6'h04;
  localparam logic [5:0]  UMC_ID_THR   = 6'h02;
  localparam logic [5:0]  UMC_ID_MODEM = 6'h00;
  localparam logic [5:0]  UMC_ID_XOFF  = 6'h10;
  localparam logic [5:0]  UMC_ID_FLOW  = 6'h20;

  // active-high modem inputs after the inversion of the pins
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } umc_modem_t;

  // interrupt sources from the datapath
  typedef struct packed {
    logic line_err;
    logic rx_timeout;
    logic rx_ready;
    logic tx_empty;
    logic xoff_char;
    logic rts_rise;
    logic cts_rise;
  } umc_src_t;

endpackage

// ==== design/umc_sync.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ns
`default_nettype none
module umc_sync
  import umc_pkg::*;
#(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  initial begin
    if (WIDTH < 1) $error("umc_sync width must be positive");
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          level[i] <= INIT[i];
        end else if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== design/umc_prescale.sv ====
// baud clock prescale strobe: every cycle or one in four
`timescale 1ns/1ns
`default_nettype none
module umc_prescale
  import umc_pkg::*;
#(
  parameter int DIV = UMC_PRESCALE_DIV
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic div_sel,
  output logic      tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] count;

  initial begin
    if (DIV < 2) $error("umc_prescale divider must be at least 2");
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
    end else if (!div_sel || count == LAST) begin
      count <= '0;
    end else begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick <= 1'b0;
    end else begin
      tick <= !div_sel || count == LAST;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/umc_modem_model.sv ====
// modem side model that drives the active-low handshake pins
`timescale 1ns/1ns
`default_nettype none
module umc_modem_model
  import umc_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire umc_modem_t want,
  input  wire logic       dtr_n,
  input  wire logic       rts_n,
  output logic            cts_n,
  output logic            dsr_n,
  output logic            ri_n,
  output logic            cd_n,
  output logic            host_ready,
  output logic            host_rts
);
  initial {cd_n, ri_n, dsr_n, cts_n} = 4'hf;
  // pins move just after an edge, like a real data set would
  always @(posedge sys_clk) {cd_n, ri_n, dsr_n, cts_n} <= ~want;
  assign host_ready = ~dtr_n;
  assign host_rts   = ~rts_n;
endmodule
`default_nettype wire

// ==== testbench/umc_modem_irq_tb_top.sv ====
// self-checking bench for the modem control and interrupt block
`timescale 1ns/1ns
`default_nettype none
module umc_modem_irq_tb_top import umc_pkg::*;;
  logic        sys_clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, c;
  logic        dtr_n, rts_n, irq, irq_oe, tx_fifo_write, rx_halt, rx_restore;
  logic        tx_serial, rx_serial_loop, loopback, fifo_rdy_en, xon_any_en;
  logic        thresh_access, baud_tick, sleep_mode, cts_n, dsr_n, ri_n, cd_n;
  logic        host_ready, host_rts;
  umc_src_t    src;
  umc_modem_t  want;
  int          err_total, tests_run, cycles;

  umc_modem_irq umc_modem_irq_inst (.sys_clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .cts_n, .dsr_n, .ri_n, .cd_n,
    .dtr_n, .rts_n, .irq, .irq_oe, .src, .tx_fifo_write, .rx_halt, .rx_restore,
    .tx_serial, .rx_serial_loop, .loopback, .fifo_rdy_en, .xon_any_en,
    .thresh_access, .baud_tick, .sleep_mode);
  umc_modem_model umc_modem_model_inst (.sys_clk, .want, .dtr_n, .rts_n, .cts_n,
    .dsr_n, .ri_n, .cd_n, .host_ready, .host_rts);

  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hang anywhere ends the run as a failure
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      complete_run;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'h1;
    @(posedge sys_clk);
    // pready high ends this wait; if it never comes, only the bench timeout does
    while (pready !== 1'h1) begin
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 8'h00);
    chk(nm, rd, exp);
  endtask

  task automatic pulse_tx;
    tx_fifo_write <= 1'h1;
    tick(1);
    tx_fifo_write <= 1'h0;
  endtask

  task automatic t_reset;
    rdc("mctl", UMC_OFS_MCTL, 32'h00);
    rdc("ien", UMC_OFS_IEN, 32'h00);
    rdc("iid", UMC_OFS_IID, 32'h01);
    chk("pins", {dtr_n, rts_n, irq_oe, irq}, 4'hc);
  endtask

  task automatic t_mctl;
    wr(UMC_OFS_MCTL, 8'hef);
    rdc("mctlp", UMC_OFS_MCTL, 32'h0f);
    chk("dtr", host_ready, 1'h1);
    chk("rts", host_rts, 1'h1);
    chk("oe", irq_oe, 1'h1);
    chk("frdy", fifo_rdy_en, 1'h1);
    wr(UMC_OFS_EFEAT, 8'h10);
    wr(UMC_OFS_MCTL, 8'he0);
    rdc("mctle", UMC_OFS_MCTL, 32'he0);
    chk("xon", xon_any_en, 1'h1);
    chk("tacc", thresh_access, 1'h1);
    chk("oe0", {irq_oe, dtr_n, rts_n}, 3'h3);
    c = '0;
    repeat (16) begin
      @(posedge sys_clk);
      c = c + baud_tick;
    end
    chk("div4", c, 32'h4);
    wr(UMC_OFS_MCTL, 8'h00);
    tick(2);
    c = '0;
    repeat (16) begin
      @(posedge sys_clk);
      c = c + baud_tick;
    end
    chk("div1", c, 32'h10);
  endtask

  task automatic t_loop;
    wr(UMC_OFS_MCTL, 8'h1f);
    tx_serial <= 1'h0;
    apb(1'h0, UMC_OFS_MSTAT, 8'h00);
    chk("lpup", rd & 32'hf0, 32'hf0);
    chk("lpo", {loopback, dtr_n, rts_n, rx_serial_loop}, 4'he);
    tx_serial <= 1'h1;
    rdc("lp0", UMC_OFS_MSTAT, 32'hf0);
    wr(UMC_OFS_MCTL, 8'h11);
    rdc("lp1", UMC_OFS_MSTAT, 32'h29);
    wr(UMC_OFS_MCTL, 8'h15);
    rdc("lp2", UMC_OFS_MSTAT, 32'h64);
    chk("rxl", rx_serial_loop, 1'h1);
    wr(UMC_OFS_MCTL, 8'h00);
    apb(1'h0, UMC_OFS_MSTAT, 8'h00);
  endtask

  task automatic t_pins;
    want <= 4'h1;
    tick(8);
    rdc("cts", UMC_OFS_MSTAT, 32'h11);
    want <= 4'h5;
    tick(8);
    rdc("rion", UMC_OFS_MSTAT, 32'h50);
    want <= 4'h1;
    tick(8);
    rdc("rioff", UMC_OFS_MSTAT, 32'h14);
    want <= 4'hb;
    tick(8);
    rdc("dsrcd", UMC_OFS_MSTAT, 32'hba);
    want <= 4'h0;
    tick(8);
    rdc("alloff", UMC_OFS_MSTAT, 32'h0b);
  endtask

  task automatic t_msirq;
    wr(UMC_OFS_IEN, 8'h08);
    want <= 4'h1;
    tick(8);
    chk("irqm", irq, 1'h1);
    rdc("iidm", UMC_OFS_IID, 32'h00);
    apb(1'h0, UMC_OFS_MSTAT, 8'h00);
    tick(2);
    chk("irq0", irq, 1'h0);
    rdc("iidn", UMC_OFS_IID, 32'h01);
  endtask

  task automatic t_ien;
    wr(UMC_OFS_EFEAT, 8'h00);
    wr(UMC_OFS_IEN, 8'hff);
    rdc("ienp", UMC_OFS_IEN, 32'h0f);
    chk("slp0", sleep_mode, 1'h0);
    wr(UMC_OFS_EFEAT, 8'h10);
    wr(UMC_OFS_IEN, 8'h10);
    rdc("iens", UMC_OFS_IEN, 32'h10);
    chk("slp", sleep_mode, 1'h1);
  endtask

  task automatic t_prio;
    logic [5:0] code [7];
    logic [6:0] msk [7];
    code = '{6'h06, 6'h0c, 6'h04, 6'h02, 6'h10, 6'h20, 6'h01};
    msk = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h04, 7'h03, 7'h00};
    wr(UMC_OFS_FCTL, 8'h01);
    src <= 7'h7f;
    wr(UMC_OFS_IEN, 8'he7);
    pulse_tx;
    for (int i = 0; i < 7; i++) begin
      tick(2);
      rdc("iidp", UMC_OFS_IID, {24'h0, 2'h3, code[i]});
      chk("irqp", irq, i < 6);
      src <= src & ~msk[i];
    end
  endtask

  task automatic t_txre;
    src <= 7'h08;
    wr(UMC_OFS_IEN, 8'h00);
    wr(UMC_OFS_IEN, 8'h02);
    rdc("txn", UMC_OFS_IID, 32'hc1);
    pulse_tx;
    tick(2);
    rdc("txy", UMC_OFS_IID, 32'hc2);
    wr(UMC_OFS_IEN, 8'h00);
    wr(UMC_OFS_IEN, 8'h02);
    rdc("txr", UMC_OFS_IID, 32'hc1);
  endtask

  task automatic t_arts;
    src <= 7'h00;
    wr(UMC_OFS_IEN, 8'h00);
    wr(UMC_OFS_MCTL, 8'h02);
    tick(2);
    chk("rtsm", rts_n, 1'h0);
    wr(UMC_OFS_EFEAT, 8'h50);
    rx_halt <= 1'h1;
    tick(3);
    chk("halt", rts_n, 1'h1);
    rx_halt <= 1'h0;
    tick(3);
    chk("hold", rts_n, 1'h1);
    rx_restore <= 1'h1;
    tick(3);
    chk("rest", rts_n, 1'h0);
    rx_restore <= 1'h0;
  endtask

  task automatic t_errs;
    apb(1'h0, 12'h020, 8'h00);
    chk("uerr", err, 1'h1);
    chk("udat", rd, 32'h0);
    apb(1'h1, UMC_OFS_IID, 8'h55);
    chk("werr", err, 1'h1);
    rdc("iidw", UMC_OFS_IID, 32'hc1);
  endtask

  initial begin
    {psel, penable, pwrite, tx_fifo_write, rx_halt, rx_restore} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    tx_serial = 1'h1;
    src = 7'h00;
    want = 4'h0;
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    reset_n = 1'h0;
    tick(12);
    reset_n <= 1'h1;
    t_reset;
    t_mctl;
    t_loop;
    t_pins;
    t_msirq;
    t_ien;
    t_prio;
    t_txre;
    t_arts;
    t_errs;
    complete_run;
  end
endmodule
`default_nettype wire
